//--- hdl/sms_pkg.sv
// Constants, register layout and state types for the byte-wide serial port.
// Assumes one core clock at CLK_PERIOD_NS for both ends of the link.
package sms_pkg;

  // Register offsets on the CPU register port.
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;
  localparam logic [1:0] ADDR_DATA = 2'h2;

  // Control register fields.
  localparam int CTRL_IRQ_EN  = 7;
  localparam int CTRL_PORT_EN = 6;
  localparam int CTRL_RATE2   = 5;
  localparam int CTRL_MASTER  = 4;
  localparam int CTRL_CLOCK_POLARITY    = 3;
  localparam int CTRL_CLOCK_PHASE    = 2;
  localparam int CTRL_RATE1   = 1;
  localparam int CTRL_RATE0   = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register fields; the other bits read as zero.
  localparam int STAT_DONE = 7;
  localparam int STAT_WRITE_COLLISION_FLAG = 6;

  // Serial byte framing: eight clock pulses give sixteen edges.
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] LAST_EDGE = 4'hF;

  // Pin positions in the synchroniser vectors.
  localparam int PIN_SCK   = 0;
  localparam int PIN_MOSI  = 1;
  localparam int PIN_MISO  = 2;
  localparam int PIN_SS    = 3;
  localparam int PIN_COUNT = 4;

  // Timing: the far end derives a 200 ns link clock from the core clock.
  localparam int CLK_PERIOD_NS  = 25;
  localparam int LINK_PERIOD_NS = 200;
  localparam int PTN_HALF = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int FIFO_DEPTH = 8;

  // Half periods of the master clock in core cycles, per rate selection.
  localparam logic [6:0] HALF_DIV4   = 7'h02;
  localparam logic [6:0] HALF_DIV8   = 7'h04;
  localparam logic [6:0] HALF_DIV16  = 7'h08;
  localparam logic [6:0] HALF_DIV32  = 7'h10;
  localparam logic [6:0] HALF_DIV64  = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;

  // Maps {rate2, rate1, rate0} to a half period; unlisted codes fall to /8.
  function automatic logic [6:0] rate_half(input logic [2:0] sel);
    case (sel)
      3'h4:    rate_half = HALF_DIV4;
      3'h1:    rate_half = HALF_DIV16;
      3'h6:    rate_half = HALF_DIV32;
      3'h2:    rate_half = HALF_DIV64;
      3'h3:    rate_half = HALF_DIV128;
      default: rate_half = HALF_DIV8;
    endcase
  endfunction

  typedef enum logic [1:0] {
    M_IDLE  = 2'b01,
    M_SHIFT = 2'b10
  } sms_mstate_type;

  typedef enum logic [4:0] {
    P_IDLE  = 5'b00001,
    P_LEAD  = 5'b00010,
    P_SHIFT = 5'b00100,
    P_TRAIL = 5'b01000,
    P_GAP   = 5'b10000
  } sms_pstate_type;

endpackage

//--- hdl/sms_link_if.sv
// Serial link between the port and its far end: clock, two data lines, select.
// Each end drives output and enable; the wire levels are resolved here.
`timescale 1ns/1ps
`default_nettype none
interface sms_link_if;
  logic dev_sck_o;
  logic dev_sck_oe;
  logic dev_mosi_o;
  logic dev_mosi_oe;
  logic dev_miso_o;
  logic dev_miso_oe;
  logic ptn_sck_o;
  logic ptn_sck_oe;
  logic ptn_mosi_o;
  logic ptn_mosi_oe;
  logic ptn_miso_o;
  logic ptn_miso_oe;
  logic ptn_ss_n_o;
  logic ptn_ss_n_oe;
  logic sck;
  logic mosi;
  logic miso;
  logic ss_n;

  // Undriven lines float to a pulled-up high level.
  assign sck  = dev_sck_oe ? dev_sck_o : (ptn_sck_oe ? ptn_sck_o : 1'b1);
  assign mosi = dev_mosi_oe ? dev_mosi_o : (ptn_mosi_oe ? ptn_mosi_o : 1'b1);
  assign miso = dev_miso_oe ? dev_miso_o : (ptn_miso_oe ? ptn_miso_o : 1'b1);
  assign ss_n = ptn_ss_n_oe ? ptn_ss_n_o : 1'b1;

  modport dev (
    output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe,
    input  sck, mosi, miso, ss_n
  );
  modport ptn (
    output ptn_sck_o, ptn_sck_oe, ptn_mosi_o, ptn_mosi_oe, ptn_miso_o, ptn_miso_oe,
    output ptn_ss_n_o, ptn_ss_n_oe,
    input  sck, mosi, miso
  );
endinterface
`default_nettype wire

//--- hdl/sms_fifo.sv
// Small first-in first-out buffer in flip-flops with valid/ready on both sides.
// DEPTH must be a power of two; clock enable low freezes it.
`timescale 1ns/1ps
`default_nettype none
module sms_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = sms_pkg::FIFO_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [CW-1:0]    cnt_q;

  // Full and empty come straight from the fill count.
  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;
  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  // Storage is not reset; only the pointers matter.
  always_ff @(posedge clock) begin
    if (clk_en && push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (clk_en) begin
      wr_q  <= push ? AW'(wr_q + 1'b1) : wr_q;
      rd_q  <= pop ? AW'(rd_q + 1'b1) : rd_q;
      cnt_q <= CW'(cnt_q + CW'(push) - CW'(pop));
    end
  end
endmodule
`default_nettype wire

//--- hdl/sms_dev.sv
// Byte-wide full-duplex serial port with CPU registers: master or slave.
// Assumes the link pins are asynchronous and the CPU port is on clock.
`timescale 1ns/1ps
`default_nettype none
module sms_dev (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic [1:0] cpu_addr,
  input  wire logic       cpu_wr,
  input  wire logic       cpu_rd,
  input  wire logic [7:0] cpu_wdata,
  output logic [7:0]      cpu_rdata,
  input  wire logic       cpu_irq_mask,
  output logic            irq_req,
  sms_link_if.dev         link
);
  logic [sms_pkg::PIN_COUNT-1:0] pin_in;
  logic [sms_pkg::PIN_COUNT-1:0] meta_q;
  logic [sms_pkg::PIN_COUNT-1:0] sync_q;
  logic [sms_pkg::PIN_COUNT-1:0] prev_q;
  logic [7:0]                    ctrl_q;
  logic [7:0]                    ctrl_d;
  logic [7:0]                    rdata_q;
  logic                          done_q;
  logic                          seen_q;
  logic                          write_collision_flag_q;
  logic                          wseen_q;
  sms_pkg::sms_mstate_type       state_q;
  logic [6:0]                    tmr_q;
  logic [6:0]                    half;
  logic                          sck_q;
  logic [3:0]                    edge_q;
  logic [7:0]                    sh_q;
  logic                          lat_q;
  logic                          out_q;
  logic [7:0]                    rx_q;

  // Two flip-flops per pin; the third stage only serves edge detection.
  assign pin_in = {link.ss_n, link.miso, link.mosi, link.sck};
  genvar g;
  generate
    for (g = 0; g < sms_pkg::PIN_COUNT; g = g + 1) begin : g_sync
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          meta_q[g] <= 1'b1;
          sync_q[g] <= 1'b1;
          prev_q[g] <= 1'b1;
        end else if (clk_en) begin
          meta_q[g] <= pin_in[g];
          sync_q[g] <= meta_q[g];
          prev_q[g] <= sync_q[g];
        end
      end
    end
  endgenerate

  // Mode decode from the control register.
  wire master  = ctrl_q[sms_pkg::CTRL_MASTER];
  wire port_en = ctrl_q[sms_pkg::CTRL_PORT_EN];
  wire clock_polarity    = ctrl_q[sms_pkg::CTRL_CLOCK_POLARITY];
  wire clock_phase    = ctrl_q[sms_pkg::CTRL_CLOCK_PHASE];
  wire ss_low  = ~sync_q[sms_pkg::PIN_SS];

  // CPU access decode.
  wire stat_hit = (cpu_addr == sms_pkg::ADDR_STAT) & (cpu_rd | cpu_wr);
  wire data_rd  = (cpu_addr == sms_pkg::ADDR_DATA) & cpu_rd;
  wire data_wr  = (cpu_addr == sms_pkg::ADDR_DATA) & cpu_wr;
  wire ctrl_wr  = (cpu_addr == sms_pkg::ADDR_CTRL) & cpu_wr;

  // slave edges come from the pin clock while selected.
  wire s_edge = port_en & ~master & ss_low
              & (sync_q[sms_pkg::PIN_SCK] != prev_q[sms_pkg::PIN_SCK]);
  wire m_edge = (state_q == sms_pkg::M_SHIFT) & (tmr_q == 7'h00);
  wire sedge  = master ? m_edge : s_edge;
  // phase set captures on even-numbered edges.
  // phase clear captures on odd-numbered edges.
  wire cap    = sedge & (edge_q[0] == clock_phase);
  wire shf    = sedge & ~cap;
  // the sixteenth edge closes the byte.
  wire last   = sedge & (edge_q == sms_pkg::LAST_EDGE);
  wire din    = master ? sync_q[sms_pkg::PIN_MISO] : sync_q[sms_pkg::PIN_MOSI];

  // phase clear slave is busy whenever selected.
  // phase set slave is busy from its first edge.
  wire s_busy = ~master & (clock_phase ? (edge_q != 4'h0) : ss_low);
  wire busy   = (state_q == sms_pkg::M_SHIFT) | s_busy;

  // a pending done flag blocks writes until status is seen.
  wire wr_block = done_q & ~seen_q;
  // writes during a transfer are dropped.
  wire wr_coll  = data_wr & ~wr_block & busy;
  wire load     = data_wr & ~wr_block & ~busy;
  // a master write starts the byte.
  wire start    = load & master & port_en;

  // rate bits pick the master half period.
  assign half = sms_pkg::rate_half({ctrl_q[sms_pkg::CTRL_RATE2],
                                    ctrl_q[sms_pkg::CTRL_RATE1],
                                    ctrl_q[sms_pkg::CTRL_RATE0]});

  // a low select while in master mode strips master mode and the port enable.
  always_comb begin
    ctrl_d = ctrl_wr ? cpu_wdata : ctrl_q;
    if (ctrl_d[sms_pkg::CTRL_MASTER] && ss_low) begin
      ctrl_d[sms_pkg::CTRL_MASTER]  = 1'b0;
      ctrl_d[sms_pkg::CTRL_PORT_EN] = 1'b0;
    end
  end

  // Control and readback; reads are answered from a register a cycle later.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_q  <= sms_pkg::CTRL_RESET;
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      ctrl_q <= ctrl_d;
      if (cpu_rd) begin
        rdata_q <= (cpu_addr == sms_pkg::ADDR_CTRL) ? ctrl_q
                 : (cpu_addr == sms_pkg::ADDR_STAT) ? {done_q, write_collision_flag_q, 6'h00}
                 : (cpu_addr == sms_pkg::ADDR_DATA) ? rx_q : 8'h00;
      end
    end
  end
  assign cpu_rdata = rdata_q;

  // done flag is set at byte end; a new byte wins over a clear.
  // status access while set arms the clear by a data read.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      done_q <= 1'b0;
      seen_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= last | (done_q & ~(data_rd & seen_q));
      seen_q <= ~last & ((stat_hit & done_q) | (seen_q & ~data_rd));
    end
  end

  // it clears after a status access then a data access.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      write_collision_flag_q  <= 1'b0;
      wseen_q <= 1'b0;
    end else if (clk_en) begin
      write_collision_flag_q  <= wr_coll | (write_collision_flag_q & ~(wseen_q & (data_rd | data_wr)));
      wseen_q <= ~wr_coll & ((stat_hit & write_collision_flag_q) | (wseen_q & ~(data_rd | data_wr)));
    end
  end

  // interrupt from the done flag only, gated by the CPU mask.
  assign irq_req = done_q & ctrl_q[sms_pkg::CTRL_IRQ_EN] & ~cpu_irq_mask;

  // master clock generator; sixteen toggles return it to idle.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= sms_pkg::M_IDLE;
      tmr_q   <= 7'h00;
      sck_q   <= 1'b0;
    end else if (clk_en) begin
      case (state_q)
        sms_pkg::M_IDLE: begin
          sck_q <= clock_polarity;
          tmr_q <= 7'(half - 7'h01);
          if (start) begin
            state_q <= sms_pkg::M_SHIFT;
          end
        end
        sms_pkg::M_SHIFT: begin
          tmr_q <= (tmr_q == 7'h00) ? 7'(half - 7'h01) : 7'(tmr_q - 7'h01);
          if (m_edge) begin
            sck_q <= ~sck_q;
          end
          if (last || !master) begin
            state_q <= sms_pkg::M_IDLE;
          end
        end
        default: state_q <= sms_pkg::M_IDLE;
      endcase
    end
  end

  // Edge count; a deselected slave starts over so it cannot lose framing.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      edge_q <= 4'h0;
    end else if (clk_en) begin
      if (last || start || (!master && !ss_low)) begin
        edge_q <= 4'h0;
      end else if (sedge) begin
        edge_q <= 4'(edge_q + 4'h1);
      end
    end
  end

  // parallel load, then shift MSB first.
  // a slave sends what was loaded earlier.
  // phase set shows the MSB only from the first edge.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sh_q  <= 8'h00;
      lat_q <= 1'b0;
      out_q <= 1'b0;
    end else if (clk_en) begin
      if (load) begin
        sh_q  <= cpu_wdata;
        out_q <= clock_phase ? out_q : cpu_wdata[sms_pkg::BYTE_BITS-1];
      end else if (shf) begin
        sh_q  <= {sh_q[6:0], lat_q};
        out_q <= clock_phase ? sh_q[7] : sh_q[6];
      end
      if (cap) begin
        lat_q <= din;
      end
    end
  end

  // the received byte is buffered on the last edge.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_q <= 8'h00;
    end else if (clk_en && last) begin
      rx_q <= {sh_q[6:0], clock_phase ? din : lat_q};
    end
  end

  assign link.dev_sck_o   = sck_q;
  assign link.dev_sck_oe  = port_en & master;
  assign link.dev_mosi_o  = out_q;
  assign link.dev_mosi_oe = port_en & master;
  assign link.dev_miso_o  = out_q;
  assign link.dev_miso_oe = port_en & ~master & ss_low;
endmodule
`default_nettype wire

//--- hdl/sms_ptn.sv
// Far end of the serial link: master with its own divided clock, or slave.
// Bytes to send wait in a FIFO; received bytes leave as a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module sms_ptn #(
  parameter int HALF = sms_pkg::PTN_HALF,
  parameter int DEPTH = sms_pkg::FIFO_DEPTH
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic       ptn_master,
  input  wire logic       clock_polarity,
  input  wire logic       clock_phase,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_data,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  sms_link_if.ptn         link
);
  localparam logic [6:0] HALF_M1 = 7'(HALF - 1);

  logic [2:0]              pin_in;
  logic [2:0]              meta_q;
  logic [2:0]              sync_q;
  logic [2:0]              prev_q;
  sms_pkg::sms_pstate_type state_q;
  logic [6:0]              tmr_q;
  logic                    sck_q;
  logic                    ss_q;
  logic [3:0]              edge_q;
  logic [7:0]              sh_q;
  logic                    lat_q;
  logic                    out_q;
  logic                    have_q;
  logic                    rxv_q;
  logic [7:0]              rx_q;
  logic                    f_valid;
  logic [7:0]              f_data;

  // Link pins pass two flip-flops; the third stage feeds edge detection.
  assign pin_in = {link.miso, link.mosi, link.sck};
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sync
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          meta_q[g] <= 1'b1;
          sync_q[g] <= 1'b1;
          prev_q[g] <= 1'b1;
        end else if (clk_en) begin
          meta_q[g] <= pin_in[g];
          sync_q[g] <= meta_q[g];
          prev_q[g] <= sync_q[g];
        end
      end
    end
  endgenerate

  // Edges: own timer as master, detected pin edges as slave.
  wire tick   = (tmr_q == 7'h00);
  wire m_edge = ptn_master & (state_q == sms_pkg::P_SHIFT) & tick;
  // A slave far end has no select, so a byte may only open on an edge that leaves
  // the idle level; the port moving its idle clock must not look like a frame.
  wire s_open = (edge_q != 4'h0) | (sync_q[sms_pkg::PIN_SCK] != clock_polarity);
  wire s_edge = ~ptn_master & s_open
              & (sync_q[sms_pkg::PIN_SCK] != prev_q[sms_pkg::PIN_SCK]);
  wire sedge  = m_edge | s_edge;
  wire cap    = sedge & (edge_q[0] == clock_phase);
  wire shf    = sedge & ~cap;
  // eight pulses, sixteen edges, per byte.
  wire last   = sedge & (edge_q == sms_pkg::LAST_EDGE);
  wire din    = ptn_master ? sync_q[sms_pkg::PIN_MISO] : sync_q[sms_pkg::PIN_MOSI];
  wire m_load = ptn_master & (state_q == sms_pkg::P_IDLE) & f_valid;
  wire s_load = ~ptn_master & (edge_q == 4'h0) & ~sedge & ~have_q & f_valid;
  wire load   = m_load | s_load;

  // The FIFO stalls the user once eight bytes wait.
  sms_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (f_valid),
    .out_ready (load),
    .out_data  (f_data)
  );

  // as master, select is held low over the whole byte.
  // and raised for a half period between bytes.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= sms_pkg::P_IDLE;
      tmr_q   <= 7'h00;
      sck_q   <= 1'b0;
      ss_q    <= 1'b1;
    end else if (clk_en) begin
      tmr_q <= tick ? HALF_M1 : 7'(tmr_q - 7'h01);
      case (state_q)
        sms_pkg::P_IDLE: begin
          sck_q <= clock_polarity;
          tmr_q <= HALF_M1;
          if (m_load) begin
            ss_q    <= 1'b0;
            state_q <= sms_pkg::P_LEAD;
          end
        end
        sms_pkg::P_LEAD:  state_q <= tick ? sms_pkg::P_SHIFT : state_q;
        sms_pkg::P_SHIFT: begin
          sck_q   <= m_edge ? ~sck_q : sck_q;
          state_q <= last ? sms_pkg::P_TRAIL : state_q;
        end
        sms_pkg::P_TRAIL: begin
          ss_q    <= tick ? 1'b1 : ss_q;
          state_q <= tick ? sms_pkg::P_GAP : state_q;
        end
        sms_pkg::P_GAP:   state_q <= tick ? sms_pkg::P_IDLE : state_q;
        default:          state_q <= sms_pkg::P_IDLE;
      endcase
    end
  end

  // Shift engine shared by both roles; same edge rules as the port.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      edge_q <= 4'h0;
      sh_q   <= 8'h00;
      lat_q  <= 1'b0;
      out_q  <= 1'b0;
      have_q <= 1'b0;
      rxv_q  <= 1'b0;
      rx_q   <= 8'h00;
    end else if (clk_en) begin
      edge_q <= last ? 4'h0 : (sedge ? 4'(edge_q + 4'h1) : edge_q);
      have_q <= ~last & (have_q | s_load);
      if (load) begin
        sh_q  <= f_data;
        out_q <= f_data[7];
      end else if (shf) begin
        sh_q  <= {sh_q[6:0], lat_q};
        out_q <= clock_phase ? sh_q[7] : sh_q[6];
      end
      lat_q <= cap ? din : lat_q;
      rxv_q <= last;
      rx_q  <= last ? {sh_q[6:0], clock_phase ? din : lat_q} : rx_q;
    end
  end

  assign rx_valid = rxv_q;
  assign rx_data  = rx_q;

  // as slave, the port's select stays high.
  assign link.ptn_ss_n_o  = ptn_master ? ss_q : 1'b1;
  assign link.ptn_ss_n_oe = 1'b1;
  assign link.ptn_sck_o   = sck_q;
  assign link.ptn_sck_oe  = ptn_master;
  assign link.ptn_mosi_o  = out_q;
  assign link.ptn_mosi_oe = ptn_master;
  assign link.ptn_miso_o  = out_q;
  assign link.ptn_miso_oe = ~ptn_master;
endmodule
`default_nettype wire

//--- sim/sms_assertions.sv
// Link checker on the resolved wires and the drive enables of both ends.
// Assumes both ends share the core clock and its synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module sms_assertions (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic dev_sck_oe,
  input wire logic dev_mosi_oe,
  input wire logic dev_miso_oe,
  input wire logic ptn_sck_oe,
  input wire logic ptn_mosi_oe,
  input wire logic ptn_miso_oe
);
  logic [4:0] edges_q;
  logic [4:0] edges_d;
  logic       sck_q;
  logic       idle_q;
  logic       idle_d;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Edges count only while selected; the last deselected level is the idle one.
  assign edges_d = ss_n ? 5'h00 : edges_q + {4'h0, sck ^ sck_q};
  assign idle_d  = ss_n ? sck : idle_q;

  // Edge count, cleared by reset so a cut frame never leaks into the next.
  always_ff @(posedge clock) begin
    edges_q <= sys_rst ? 5'h00 : edges_d;
    sck_q   <= sck;
    idle_q  <= idle_d;
  end

  a_sck_one_driver: assert property (!(dev_sck_oe && ptn_sck_oe))
    else $error("sck driven by both ends");
  a_mosi_one_driver: assert property (!(dev_mosi_oe && ptn_mosi_oe))
    else $error("mosi driven by both ends");
  a_miso_one_driver: assert property (!(dev_miso_oe && ptn_miso_oe))
    else $error("miso driven by both ends");
  a_master_pin_roles: assert property (dev_sck_oe |-> dev_mosi_oe && !dev_miso_oe)
    else $error("master pin directions wrong");
  a_slave_pin_roles: assert property (dev_miso_oe |-> !dev_sck_oe && !dev_mosi_oe)
    else $error("slave pin directions wrong");
  a_rate_half_min: assert property (
    dev_sck_oe && $past(dev_sck_oe) && $changed(sck) |=> $stable(sck))
    else $error("master clock half period below two cycles");
  a_frame_sixteen: assert property ($rose(ss_n) |-> edges_q == 5'h10)
    else $error("frame without sixteen clock edges");
  a_idle_level: assert property ($rose(ss_n) |-> sck == idle_q)
    else $error("clock not back at idle level");
  a_idle_hold: assert property ($rose(ss_n) |=> $stable(sck) [*2])
    else $error("clock moved after frame end");

  c_far_frame: cover property ($rose(ss_n));
  c_master_clock: cover property (dev_sck_oe && $changed(sck));
  c_slave_out: cover property (dev_miso_oe && !ss_n);
endmodule
`default_nettype wire

//--- sim/spi_master_slave_shifter_tb_top.sv
// Port end against the far end over one link; queues predict every byte.
// Assumes a shared 40 MHz core clock; the far master runs at half its default rate.
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_shifter_tb_top;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic [1:0] cpu_addr = 2'h0;
  logic       cpu_wr = 1'b0;
  logic       cpu_rd = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata;
  logic       cpu_irq_mask = 1'b0;
  logic       irq_req;
  logic       ptn_master = 1'b0;
  logic       clock_polarity = 1'b0;
  logic       clock_phase = 1'b0;
  logic       tx_valid = 1'b0;
  logic       tx_ready;
  logic [7:0] tx_data = 8'h00;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic [7:0] rx_q[$];
  logic [7:0] rd;
  logic [2:0] rate_tab[6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
  int         err_total = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         n;

  sms_link_if link ();
  sms_dev sms_dev_i (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_irq_mask(cpu_irq_mask), .irq_req(irq_req), .link(link));
  // The port answers a far master three core cycles late, so the far master is slowed.
  sms_ptn #(.HALF(2 * sms_pkg::PTN_HALF)) sms_ptn_i (.clock(clock), .sys_rst(sys_rst),
    .clk_en(1'b1), .ptn_master(ptn_master),
    .clock_polarity(clock_polarity), .clock_phase(clock_phase), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_data(rx_data), .link(link));
  sms_assertions sms_assertions_i (.clock(clock), .sys_rst(sys_rst), .sck(link.sck),
    .ss_n(link.ss_n), .dev_sck_oe(link.dev_sck_oe), .dev_mosi_oe(link.dev_mosi_oe),
    .dev_miso_oe(link.dev_miso_oe), .ptn_sck_oe(link.ptn_sck_oe),
    .ptn_mosi_oe(link.ptn_mosi_oe), .ptn_miso_oe(link.ptn_miso_oe));

  // Core clock; the far end divides it down for the link.
  always #12.5 clock = ~clock;

  // Bytes the far end received, plus a ceiling on run length.
  always @(posedge clock) begin
    if (rx_valid === 1'b1) rx_q.push_back(rx_data);
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One register cycle; read data is taken the cycle after the strobe.
  task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(negedge clock);
    cpu_wr = w;
    cpu_rd = !w;
    cpu_addr = a;
    cpu_wdata = d;
    @(negedge clock);
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    rd = cpu_rdata;
  endtask

  // One byte exchange in either direction, optionally with a colliding write.
  task automatic xfer(input logic [7:0] ctl, input logic coll);
    logic [7:0] bp;
    logic [7:0] bf;
    int k;
    bp = 8'($urandom);
    bf = 8'($urandom);
    // A far slave answers late, so at /4 and /8 it returns a byte of equal bits.
    if (ctl[4] && !ctl[1] && !ctl[0]) bf = {8{bf[0]}};
    clock_polarity = ctl[3];
    clock_phase = ctl[2];
    acc(1'b1, 2'h0, ctl);
    if (!ctl[4]) acc(1'b1, 2'h2, bp);
    @(negedge clock);
    tx_valid = 1'b1;
    tx_data = bf;
    @(negedge clock);
    tx_valid = 1'b0;
    if (ctl[4]) acc(1'b1, 2'h2, bp);
    if (coll) begin
      repeat (20) @(negedge clock);
      acc(1'b1, 2'h2, ~bp);
    end
    k = 0;
    while (irq_req !== 1'b1 && k < 3000) begin
      @(negedge clock);
      k++;
    end
    acc(1'b1, 2'h2, ~bp);
    cpu_irq_mask = 1'($urandom);
    @(negedge clock);
    chk({7'h00, irq_req}, {7'h00, !cpu_irq_mask}, "irq");
    cpu_irq_mask = 1'b0;
    acc(1'b0, 2'h1, 8'h00);
    chk(rd, coll ? 8'hC0 : 8'h80, "status at end");
    acc(1'b0, 2'h2, 8'h00);
    chk(rd, bf, "port rx byte");
    acc(1'b0, 2'h1, 8'h00);
    chk(rd, 8'h00, "status cleared");
    repeat (8) @(negedge clock);
    chk(rx_q.size() > 0 ? rx_q.pop_front() : ~bp, bp, "far rx byte");
  endtask

  initial begin
    void'($urandom(32'hBBFC));
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
    // Port as master at every rate; collision at the /8 rate.
    for (n = 0; n < 6; n++)
      xfer({2'b11, rate_tab[n][2], 1'b1, n[1], n[0], rate_tab[n][1:0]}, n == 1);
    acc(1'b1, 2'h0, 8'h40);
    ptn_master = 1'b1;
    // Port as slave in all four clock modes; rate bits must not matter.
    for (n = 0; n < 4; n++)
      xfer({2'b11, n[0], 1'b0, n[1], n[0], n[1:0]}, n[0] == n[1]);
    chk(8'(rx_q.size()), 8'h00, "extra bytes");
    // Fill the far end's buffer until it refuses.
    n = 0;
    tx_valid = 1'b1;
    while (tx_ready === 1'b1 && n < 20) begin
      tx_data = 8'($urandom);
      @(negedge clock);
      n++;
    end
    tx_valid = 1'b0;
    chk(8'(n >= 8 && n <= 9), 8'h01, "buffer depth");
    test_done();
  end
endmodule
`default_nettype wire
